// file: logic/lineif_receive_output_port.sv
`timescale 1ns/1ps
`include "lineif_rx_cfg.svh"

module lineif_receive_output_port
    import lineif_rx_pkg::*;
#(
    parameter int NCH   = `LIF_NUM_CHANNELS,
    parameter int DEPTH = `LIF_PIPE_DEPTH
) (
    input  wire logic           mclk_i,
    input  wire logic           rst_n_i,
    input  wire logic           host_mode_i,
    input  wire logic           command_register_reset_n_i,
    input  wire logic           rail_format_select_i,
    input  wire logic [NCH-1:0] pll_clock_i,
    input  wire logic [NCH-1:0] line_in_tip_i,
    input  wire logic [NCH-1:0] line_in_ring_i,
    input  wire logic [NCH-1:0] tx_negative_rail_in_i,
    input  wire logic [NCH-1:0] line_code_hdb3_i,
    input  wire logic [NCH-1:0] rx_equalizer_enable_i,
    input  wire logic           cmd_write_i,
    input  wire logic           cmd_invert_i,
    input  wire logic [NCH-1:0] cmd_equalizer_i,
    output logic      [NCH-1:0] recovered_rx_clock_o,
    output logic      [NCH-1:0] rx_positive_rail_out_o,
    output logic      [NCH-1:0] rx_negative_rail_out_o,
    output logic      [NCH-1:0] rx_equalizer_on_o
);

    localparam int SW = 6 * NCH + 3;

    logic [SW-1:0]               meta_reg;
    logic [SW-1:0]               sync_reg;
    logic [NCH-1:0]              clk_s;
    logic [NCH-1:0]              tip_s;
    logic [NCH-1:0]              ring_s;
    logic [NCH-1:0]              txn_s;
    logic [NCH-1:0]              hdb3_s;
    logic [NCH-1:0]              eq_s;
    logic                        host_s;
    logic                        shared_s;
    logic                        fmt_s;
    logic [NCH-1:0]              clk_d_reg;
    logic [NCH-1:0]              rise;
    logic [NCH-1:0]              fall;
    logic [NCH-1:0]              upd_ev;
    logic                        upd_fall;
    logic                        clk_inv;
    logic                        cmd_inv_reg;
    logic                        cmd_inv_next;
    logic [NCH-1:0]              cmd_eq_reg;
    logic [NCH-1:0]              cmd_eq_next;
    logic [NCH-1:0][DEPTH-1:0]   pipe_p_reg;
    logic [NCH-1:0][DEPTH-1:0]   pipe_p_next;
    logic [NCH-1:0][DEPTH-1:0]   pipe_n_reg;
    logic [NCH-1:0][DEPTH-1:0]   pipe_n_next;
    logic [NCH-1:0]              last_pol_reg;
    logic [NCH-1:0]              last_pol_next;
    logic [NCH-1:0]              viol;
    logic [NCH-1:0]              clk_out_reg;
    logic [NCH-1:0]              clk_out_next;
    logic [NCH-1:0]              pos_reg;
    logic [NCH-1:0]              pos_next;
    logic [NCH-1:0]              neg_reg;
    logic [NCH-1:0]              neg_next;
    logic [NCH-1:0]              eq_reg;
    logic [NCH-1:0]              eq_next;

    // two-stage synchroniser for every pin except the command write, invert and equalizer inputs, and for the recovered clock
    // pin synchronisation
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= {host_mode_i, command_register_reset_n_i, rail_format_select_i,
                         rx_equalizer_enable_i, line_code_hdb3_i, tx_negative_rail_in_i,
                         line_in_ring_i, line_in_tip_i, pll_clock_i};
            sync_reg <= meta_reg;
        end
    end

    assign {host_s, shared_s, fmt_s, eq_s, hdb3_s, txn_s, ring_s, tip_s, clk_s} = sync_reg;

    // edges of the synchronised recovered clock
    assign rise = clk_s & ~clk_d_reg;
    assign fall = ~clk_s & clk_d_reg;

    assign upd_fall = host_s & cmd_inv_reg;
    assign clk_inv  = ~host_s & shared_s;

    // hardware mode keeps the rising edge
    assign upd_ev = upd_fall ? fall : rise;

    // command register: written by software, reset from the shared pin
    always_comb begin
        cmd_inv_next = cmd_inv_reg;
        cmd_eq_next  = cmd_eq_reg;
        if (host_s && !shared_s) begin
            cmd_inv_next = `LIF_CMD_INV_DEFAULT;
            cmd_eq_next  = {NCH{`LIF_CMD_EQ_DEFAULT}};
        end else if (cmd_write_i) begin
            cmd_inv_next = cmd_invert_i;
            cmd_eq_next  = cmd_equalizer_i;
        end
    end

    // per-channel decode and rail output next values
    always_comb begin
        logic [DEPTH-1:0] pp;
        logic [DEPTH-1:0] pn;
        logic             in_p;
        logic             in_n;
        pp            = '0;
        pn            = '0;
        in_p          = 1'b0;
        in_n          = 1'b0;
        pipe_p_next   = pipe_p_reg;
        pipe_n_next   = pipe_n_reg;
        last_pol_next = last_pol_reg;
        viol          = '0;
        pos_next      = pos_reg;
        neg_next      = neg_reg;
        for (int c = 0; c < NCH; c++) begin
            pp   = pipe_p_reg[c];
            pn   = pipe_n_reg[c];
            in_p = tip_s[c] & ~ring_s[c];
            in_n = ring_s[c] & ~tip_s[c];
            if (rise[c]) begin
                if (in_p || in_n) begin
                    // codec enabled while transmit negative rail is low
                    viol[c]          = (in_p == last_pol_reg[c]) & ~txn_s[c];
                    last_pol_next[c] = in_p;
                end
                // drop violation and its bipolar pulse
                if (viol[c]) begin
                    in_p = 1'b0;
                    in_n = 1'b0;
                    if (line_code_t'(hdb3_s[c]) == CODE_HDB3) begin
                        pp[`LIF_HDB3_B_SLOT] = 1'b0;
                        pn[`LIF_HDB3_B_SLOT] = 1'b0;
                    end else begin
                        pp[`LIF_B3ZS_B_SLOT] = 1'b0;
                        pn[`LIF_B3ZS_B_SLOT] = 1'b0;
                    end
                end
                pipe_p_next[c] = {pp[DEPTH-2:0], in_p};
                pipe_n_next[c] = {pn[DEPTH-2:0], in_n};
            end
            if (upd_ev[c]) begin
                // single-rail merges marks onto the positive rail
                if (fmt_s) begin
                    pos_next[c] = pipe_p_reg[c][DEPTH-1] | pipe_n_reg[c][DEPTH-1];
                    neg_next[c] = 1'b0;
                end else begin
                    pos_next[c] = pipe_p_reg[c][DEPTH-1];
                    neg_next[c] = pipe_n_reg[c][DEPTH-1];
                end
            end
        end
    end

    // receive clock follows the recovered timing
    assign clk_out_next = clk_s ^ {NCH{clk_inv}};

    // software mode uses the command bit
    assign eq_next = host_s ? cmd_eq_reg : eq_s;

    // state and output registers
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clk_d_reg    <= '0;
            cmd_inv_reg  <= `LIF_CMD_INV_DEFAULT;
            cmd_eq_reg   <= {NCH{`LIF_CMD_EQ_DEFAULT}};
            pipe_p_reg   <= '0;
            pipe_n_reg   <= '0;
            last_pol_reg <= {NCH{`LIF_LAST_POL_DEFAULT}};
            clk_out_reg  <= '0;
            pos_reg      <= '0;
            neg_reg      <= '0;
            eq_reg       <= '0;
        end else begin
            clk_d_reg    <= clk_s;
            cmd_inv_reg  <= cmd_inv_next;
            cmd_eq_reg   <= cmd_eq_next;
            pipe_p_reg   <= pipe_p_next;
            pipe_n_reg   <= pipe_n_next;
            last_pol_reg <= last_pol_next;
            clk_out_reg  <= clk_out_next;
            pos_reg      <= pos_next;
            neg_reg      <= neg_next;
            eq_reg       <= eq_next;
        end
    end

    assign recovered_rx_clock_o   = clk_out_reg;
    assign rx_positive_rail_out_o = pos_reg;
    assign rx_negative_rail_out_o = neg_reg;
    assign rx_equalizer_on_o      = eq_reg;

    // checks on channel 0, except the command register reset check, which covers every channel
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_rise_plain;
        $rose(clk_s[0]) && !clk_inv;
    endsequence
    sequence s_rise_inv;
        $rose(clk_s[0]) && clk_inv;
    endsequence
    sequence s_single_update;
        fmt_s [*2] ##0 upd_ev[0];
    endsequence

    property p_clk_track;
        s_rise_plain |=> recovered_rx_clock_o[0];
    endproperty
    a_clk_track: assert property (p_clk_track) else $error("receive clock missed rising edge");

    property p_clk_invert;
        s_rise_inv |=> !recovered_rx_clock_o[0];
    endproperty
    a_clk_invert: assert property (p_clk_invert) else $error("receive clock not inverted");

    property p_update_edge;
        $changed(rx_positive_rail_out_o[0]) |-> $past(upd_ev[0]);
    endproperty
    a_update_edge: assert property (p_update_edge) else $error("positive rail changed off edge");

    property p_rise_hold;
        upd_fall && rise[0] |=> $stable(rx_positive_rail_out_o[0]) && $stable(rx_negative_rail_out_o[0]);
    endproperty
    a_rise_hold: assert property (p_rise_hold) else $error("rails moved on rising edge");

    property p_one_polarity;
        rx_negative_rail_out_o[0] |-> !rx_positive_rail_out_o[0];
    endproperty
    a_one_polarity: assert property (p_one_polarity) else $error("both rails high");

    property p_violation_drop;
        viol[0] |=> !pipe_p_reg[0][0] && !pipe_n_reg[0][0];
    endproperty
    a_violation_drop: assert property (p_violation_drop) else $error("violation pulse kept");

    property p_hw_eq;
        !host_s [*2] |=> rx_equalizer_on_o[0] == $past(eq_s[0]);
    endproperty
    a_hw_eq: assert property (p_hw_eq) else $error("equalizer ignores pin");

    property p_sw_eq;
        host_s [*2] |=> rx_equalizer_on_o[0] == $past(cmd_eq_reg[0]);
    endproperty
    a_sw_eq: assert property (p_sw_eq) else $error("equalizer follows pin in software mode");

    property p_reg_reset;
        host_s && !shared_s |=> !cmd_inv_reg && cmd_eq_reg == '0;
    endproperty
    a_reg_reset: assert property (p_reg_reset) else $error("command register not reset");

    property p_single_rail;
        s_single_update |=> !rx_negative_rail_out_o[0];
    endproperty
    a_single_rail: assert property (p_single_rail) else $error("negative rail active in single-rail");

endmodule

// file: logic/lineif_rx_cfg.svh
`ifndef LINEIF_RX_CFG_SVH
`define LINEIF_RX_CFG_SVH

// number of receive channels
`define LIF_NUM_CHANNELS 3
// depth of the zero-substitution removal delay line
`define LIF_PIPE_DEPTH 4
// delay-line slot holding the bipolar pulse of a four-bit substitution
`define LIF_HDB3_B_SLOT 2
// delay-line slot holding the bipolar pulse of a three-bit substitution
`define LIF_B3ZS_B_SLOT 1
// defaults of the command register fields
`define LIF_CMD_INV_DEFAULT 1'b0
`define LIF_CMD_EQ_DEFAULT 1'b0
// reset polarity memory: last pulse taken as negative
`define LIF_LAST_POL_DEFAULT 1'b0

`endif

// file: logic/lineif_rx_pkg.sv
package lineif_rx_pkg;

    // line code used by the substitution decoder
    typedef enum logic {
        CODE_B3ZS = 1'b0,
        CODE_HDB3 = 1'b1
    } line_code_t;

endpackage

// file: verification/lineif_receive_output_port_tb.sv
`timescale 1ns/1ps
module lineif_receive_output_port_tb;
    localparam int NS = 40;
    logic        mclk = '0, rst_n = '0, host = '0, shr = '1, srail = '0, cwr = '0, cinv = '0, pll = '0, clr = '0;
    logic [2:0]  tip = '0, ring = '0, txneg = '0, hdb3 = '0, eqpin = '0, ceq = '0, rclk, pos, neg, eqon;
    logic [1:0]  sym [3][NS];
    logic [1:0]  ex  [3][NS];
    logic [31:0] seed = 32'h0000000a;
    int          n_mismatch = 0, checks_done = 0, cycles = 0;
    wire logic   srise = host ? cinv : shr;

    lineif_receive_output_port i_dut (.mclk_i(mclk), .rst_n_i(rst_n), .host_mode_i(host),
        .command_register_reset_n_i(shr), .rail_format_select_i(srail), .pll_clock_i({3{pll}}),
        .line_in_tip_i(tip), .line_in_ring_i(ring), .tx_negative_rail_in_i(txneg), .line_code_hdb3_i(hdb3),
        .rx_equalizer_enable_i(eqpin), .cmd_write_i(cwr), .cmd_invert_i(cinv), .cmd_equalizer_i(ceq),
        .recovered_rx_clock_o(rclk), .rx_positive_rail_out_o(pos), .rx_negative_rail_out_o(neg),
        .rx_equalizer_on_o(eqon));
    rx_framer_model i_framer (.mclk_i(mclk), .samp_rise_i(srise), .clr_i(clr), .rx_clk_i(rclk),
        .pos_i(pos), .neg_i(neg));

    // system clock and a free-running recovered clock of unrelated phase
    always #2.5 mclk = ~mclk;
    initial begin
        #0.7;
        forever #32 pll = ~pll;
    end

    // hang guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            tally_and_finish;
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    // expected rails of one channel from the sent symbols
    function automatic void decode(input int c, input logic dec, input logic hd, input logic sr);
        logic last;
        int   back;
        last = 1'h0;
        back = hd ? 3 : 2;
        for (int k = 0; k < NS; k++) begin
            ex[c][k] = sym[c][k];
            if (sym[c][k] != 2'h0) begin
                if (dec && sym[c][k][1] == last) begin
                    ex[c][k] = 2'h0;
                    if (k >= back) ex[c][k-back] = 2'h0;
                end
                last = sym[c][k][1];
            end
        end
        for (int k = 0; k < NS; k++) if (sr) ex[c][k] = {|ex[c][k], 1'h0};
    endfunction

    task automatic cmp_val(input string what, input logic [2:0] exp, input logic [2:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_rail(input int c, input int k, input logic [1:0] exp, input logic [1:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] rails ch%0d bit%0d expected %b seen %b", c, k, exp, got);
        end
    endtask

    task automatic cmd_wr(input logic inv, input logic [2:0] eq);
        @(negedge mclk);
        cwr = 1'h1;
        cinv = inv;
        ceq = eq;
        @(negedge mclk);
        cwr = 1'h0;
    endtask

    // one frame of random line symbols; the framer result is aligned on the first mark
    task automatic run_frame(input logic h, sh, sr, input logic [2:0] tn, hd, input logic ci);
        int         idx;
        logic [1:0] got;
        @(negedge mclk);
        host = h;
        shr = sh;
        srail = sr;
        txneg = tn;
        hdb3 = hd;
        repeat (4) @(negedge mclk);
        if (h) cmd_wr(ci, ceq);
        repeat (3) @(negedge pll);
        @(posedge pll);
        #25 cmp_val("rx_clock", {3{~(sh & ~h)}}, rclk); // clock polarity
        @(negedge mclk) clr = 1'h1;
        @(negedge mclk) clr = 1'h0;
        for (int c = 0; c < 3; c++) begin
            for (int k = 0; k < NS; k++) begin
                seed = xs(seed);
                sym[c][k] = (k == 0) ? 2'h2 : (k < 4) ? 2'h0 : (k == NS - 1) ? 2'h1 :
                            (seed[1:0] == 2'h3) ? 2'h0 : seed[1:0];
            end
            decode(c, ~tn[c], hd[c], sr);
        end
        for (int k = 0; k < NS + 10; k++) begin
            @(negedge pll);
            @(negedge mclk);
            for (int c = 0; c < 3; c++) {tip[c], ring[c]} = (k < NS) ? sym[c][k] : 2'h0;
        end
        repeat (4) @(negedge pll);
        for (int c = 0; c < 3; c++) begin
            idx = 0;
            while (idx < i_framer.cap[c].size() - 1 && i_framer.cap[c][idx] == 2'h0) idx++;
            for (int k = 0; k < NS; k++) begin
                got = (idx + k < i_framer.cap[c].size()) ? i_framer.cap[c][idx+k] : 2'hx;
                cmp_rail(c, k, ex[c][k], got); // rail stream
            end
        end
        cmp_val("edge_err", 3'h0, {2'h0, i_framer.edge_err != 0}); // update edge
    endtask

    task automatic tally_and_finish;
        if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        repeat (3) @(negedge mclk);
        rst_n = 1'h1;
        repeat (4) @(negedge mclk);
        seed = xs(seed);
        eqpin = seed[2:0];
        repeat (5) @(negedge mclk);
        cmp_val("eq_hw", seed[2:0], eqon); // pin drives equalizer
        host = 1'h1;
        repeat (5) @(negedge mclk);
        cmd_wr(1'h0, 3'h5);
        eqpin = 3'h2;
        repeat (5) @(negedge mclk);
        cmp_val("eq_sw", 3'h5, eqon); // pin ignored
        shr = 1'h0;
        repeat (4) @(negedge mclk);
        cmd_wr(1'h0, 3'h7);
        shr = 1'h1;
        repeat (5) @(negedge mclk);
        cmp_val("eq_reset", 3'h0, eqon); // defaults restored
        run_frame(1'h0, 1'h0, 1'h0, 3'h0, 3'h7, 1'h0); // rising edge
        run_frame(1'h0, 1'h0, 1'h0, 3'h0, 3'h0, 1'h0); // three-bit removal
        run_frame(1'h0, 1'h1, 1'h0, 3'h0, 3'h5, 1'h0); // hardware invert
        run_frame(1'h1, 1'h1, 1'h0, 3'h0, 3'h2, 1'h1); // software invert
        run_frame(1'h0, 1'h0, 1'h0, 3'h7, 3'h0, 1'h0); // decoder off
        run_frame(1'h0, 1'h0, 1'h1, 3'h2, 3'h3, 1'h0); // single rail
        tally_and_finish;
    end
endmodule

// file: verification/rx_framer_model.sv
`timescale 1ns/1ps
// terminal-side framer: takes the rails on the clock edge away from the update edge
module rx_framer_model #(
    parameter int NCH = 3
) (
    input  wire logic           mclk_i,
    input  wire logic           samp_rise_i,
    input  wire logic           clr_i,
    input  wire logic [NCH-1:0] rx_clk_i,
    input  wire logic [NCH-1:0] pos_i,
    input  wire logic [NCH-1:0] neg_i
);
    logic [NCH-1:0] clk_d = '0;
    logic [NCH-1:0] pos_d = '0;
    logic [NCH-1:0] neg_d = '0;
    logic [1:0]     cap [NCH][$];
    int             edge_err = 0;

    // capture per channel; rails that move at the sampling edge are counted as errors
    always @(posedge mclk_i) begin
        for (int c = 0; c < NCH; c++) begin
            if (clr_i) begin
                cap[c].delete();
                edge_err = 0;
            end else if (clk_d[c] !== rx_clk_i[c] && rx_clk_i[c] === samp_rise_i) begin
                cap[c].push_back({pos_i[c], neg_i[c]});
                if ({pos_i[c], neg_i[c]} !== {pos_d[c], neg_d[c]}) edge_err++;
            end
        end
        clk_d <= rx_clk_i;
        pos_d <= pos_i;
        neg_d <= neg_i;
    end
endmodule
